// file: hw/lrc_map.svh
// lrc_map.svh: register offsets, field positions, reset values and timing figures of the LED control bank
// assumes: included by bare name from the package and design files
`ifndef LRC_MAP_SVH
`define LRC_MAP_SVH

// ==================================================
// register offsets
`define LRC_ADDR_CONFIG      8'h08
`define LRC_ADDR_PC_RED      8'h09
`define LRC_ADDR_PC_GREEN    8'h0A
`define LRC_ADDR_PC_BLUE     8'h0B
`define LRC_ADDR_STATUS      8'h0C
`define LRC_ADDR_SOFT_RESET  8'h0D
`define LRC_ADDR_OUTPUT_CTL  8'h0E
`define LRC_ADDR_MEM_FIRST   8'h10
`define LRC_ADDR_MEM_LAST    8'h6F
`define LRC_MEM_DEPTH        96

// ==================================================
// field positions and masks
`define LRC_CFG_MASK         8'h7F
`define LRC_PC_MASK          8'h0F
`define LRC_OUT_MASK         8'h07
`define LRC_STAT_EXT_BIT     3
`define LRC_OUT_IRQ_AS_OUT   2
`define LRC_OUT_GEN_PIN      1
`define LRC_OUT_IRQ_LEVEL    0
`define LRC_SOFT_RESET_KEY   8'hFF

// ==================================================
// reset values
`define LRC_RST_CONFIG       8'h00
`define LRC_RST_PC           4'h0
`define LRC_RST_STATUS       3'h0
`define LRC_RST_OUTPUT_CTL   3'h0

// ==================================================
// timing
`define LRC_CLK_HZ           100000000
`define LRC_INT_OSC_HZ       32768
`define LRC_PWM_FREQ_SELECT_HZ        558
`define LRC_SLOW_PER_PWM     128

`endif

// file: hw/lrc_pkg.sv
// lrc_pkg: types of the LED control register bank
// assumes: lrc_map.svh on the include path
`include "lrc_map.svh"

package lrc_pkg;

   // ==================================================
   // controller clock source
   typedef enum logic [1:0] {
      CLK_EXT  = 2'b00,
      CLK_INT  = 2'b01,
      CLK_AUTO = 2'b10,
      CLK_INT2 = 2'b11
   } lrc_clk_src_e;

   // ==================================================
   // configuration register layout, bit 7 first
   typedef struct packed {
      logic         spare;
      logic         pwm_freq_select;
      logic         power_save_enable;
      logic [1:0]   pump_gain_select;
      logic         red_supply_from_battery;
      lrc_clk_src_e clk_src;
   } lrc_cfg_s;

   // ==================================================
   // decoded serial bus byte transaction and its answer
   typedef struct packed {
      logic       vld;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lrc_req_s;

   typedef struct packed {
      logic       vld;
      logic       ack;
      logic [7:0] rdata;
   } lrc_rsp_s;

endpackage

// file: hw/lrc_prog_mem.sv
// lrc_prog_mem: program byte memory, cleared at reset, registered read data
// assumes: one clock, write index already range-checked by the caller; read index checked against DEPTH here
`timescale 1ns/1ps
`include "lrc_map.svh"

module lrc_prog_mem #(
   parameter int DEPTH = `LRC_MEM_DEPTH,
   parameter int AW    = 7,
   parameter int DW    = 8
) (
   // clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_b,
   // access
   input  wire logic          i_clear,
   input  wire logic          i_wr,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   output logic      [DW-1:0] o_rdata
);

   logic [DW-1:0] mem_r [DEPTH];

   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
      $error("lrc_prog_mem: depth does not fit the index width");
   end

   // ==================================================
   // storage, one flop word per entry
   for (genvar k = 0; k < DEPTH; k++) begin : g_word
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            mem_r[k] <= '0;
         end else if (i_clear) begin
            mem_r[k] <= '0;
         end else if (i_wr && i_addr == AW'(k)) begin
            mem_r[k] <= i_wdata;
         end
      end
   end

   // ==================================================
   // registered read
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (int'(i_addr) < DEPTH) begin
         o_rdata <= mem_r[i_addr];
      end else begin
         o_rdata <= '0;
      end
   end

endmodule

// file: hw/lrc_regs.sv
// lrc_regs: configuration, program counter, status and output control registers of a three-channel LED sequencer
// assumes: serial bus front end hands over decoded byte transactions; channel engines drive irq and step pulses
// Summary of operation
// - configuration bit 6 picks 256 Hz slow-clock PWM tick or 558 Hz internal tick.
// - configuration bit 5 high enables automatic power save.
// - bits 4:3 pick pump gain: off, forced 1x, forced 1.5x, automatic.
// - configuration bit 2 feeds red output from battery instead of pump.
// - bits 1:0 pick controller clock: external, internal, automatic, internal.
// - each channel has a 4-bit program counter at 09h, 0Ah, 0Bh, reset zero.
// - status bit 3 reads one when the external slow clock is in use.
// - status bits 2, 1, 0 are red, green, blue interrupt flags.
// - reading status clears the flags; active-low interrupt pin then goes high unless output control bit 2 reuses it.
// - writing FFh to 0Dh resets all registers and that write gets no acknowledge.
// - output control bit 2 makes the interrupt pin a general output.
// - output control bit 1 drives the general pin, bit 0 the reused interrupt pin.
`timescale 1ns/1ps
`include "lrc_map.svh"

module lrc_regs #(
   parameter int INT_OSC_CYC = `LRC_CLK_HZ / `LRC_INT_OSC_HZ,
   parameter int PWM_FREQ_SELECT_CYC  = `LRC_CLK_HZ / `LRC_PWM_FREQ_SELECT_HZ,
   parameter int SLOW_DIV    = `LRC_SLOW_PER_PWM
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   // register transactions
   input  wire lrc_pkg::lrc_req_s i_reg_req,
   output lrc_pkg::lrc_rsp_s      o_reg_rsp,
   // channel engines
   input  wire logic [2:0]        i_execution_mode_hold,
   input  wire logic [2:0]        i_chan_irq,
   input  wire logic [2:0]        i_pc_step,
   // clock sources
   input  wire logic              i_slow_clock_input,
   input  wire logic              i_ext_clock_present,
   // configuration and counters
   output lrc_pkg::lrc_cfg_s      o_cfg,
   output logic [2:0][3:0]        o_pc_value,
   output logic                   o_external_clock_in_use,
   output logic                   o_ctrl_tick,
   output logic                   o_pwm_tick,
   output logic                   o_soft_reset,
   // pins
   output logic                   o_irq_pin_b,
   output logic                   o_general_output_pin
);

   localparam int OW = $clog2(INT_OSC_CYC + 1);
   localparam int HW = $clog2(PWM_FREQ_SELECT_CYC + 1);
   localparam int SW = $clog2(SLOW_DIV + 1);

   if (INT_OSC_CYC < 2 || PWM_FREQ_SELECT_CYC < 2 || SLOW_DIV < 2) begin : g_chk
      $error("lrc_regs: divider counts must be at least 2");
   end

   // ==================================================
   // request decode
   logic       wr_en;
   logic       rd_en;
   logic       sreset;
   logic       mem_hit;
   logic [7:0] mem_off;
   logic       status_rd;

   assign wr_en     = i_reg_req.vld && i_reg_req.wr;
   assign rd_en     = i_reg_req.vld && !i_reg_req.wr;
   assign sreset    = wr_en && i_reg_req.addr == `LRC_ADDR_SOFT_RESET
                      && i_reg_req.wdata == `LRC_SOFT_RESET_KEY;
   assign mem_hit   = i_reg_req.addr >= `LRC_ADDR_MEM_FIRST && i_reg_req.addr <= `LRC_ADDR_MEM_LAST;
   assign mem_off   = i_reg_req.addr - `LRC_ADDR_MEM_FIRST;
   assign status_rd = rd_en && i_reg_req.addr == `LRC_ADDR_STATUS;

   // ==================================================
   // configuration register
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg <= lrc_pkg::lrc_cfg_s'(`LRC_RST_CONFIG);
      end else if (sreset) begin
         o_cfg <= lrc_pkg::lrc_cfg_s'(`LRC_RST_CONFIG);
      end else if (wr_en && i_reg_req.addr == `LRC_ADDR_CONFIG) begin
         o_cfg <= lrc_pkg::lrc_cfg_s'(i_reg_req.wdata & `LRC_CFG_MASK);
      end
   end

   // ==================================================
   // clock source selection
   logic ext_sel;

   always_comb begin
      unique case (o_cfg.clk_src)
         lrc_pkg::CLK_EXT:  ext_sel = 1'b1;
         lrc_pkg::CLK_INT:  ext_sel = 1'b0;
         lrc_pkg::CLK_AUTO: ext_sel = i_ext_clock_present;
         lrc_pkg::CLK_INT2: ext_sel = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_external_clock_in_use <= 1'b0;
      end else begin
         o_external_clock_in_use <= ext_sel;
      end
   end

   // ==================================================
   // slow clock edge, internal 32 kHz and 558 Hz dividers
   logic          slow_prev_r;
   logic          slow_edge;
   logic [OW-1:0] osc_cnt_r;
   logic          osc_tick;
   logic [HW-1:0] hf_cnt_r;
   logic          hf_tick;
   logic [SW-1:0] lf_cnt_r;
   logic          lf_tick;
   logic          ctrl_tick;

   assign slow_edge = i_slow_clock_input && !slow_prev_r;
   assign osc_tick  = osc_cnt_r == OW'(INT_OSC_CYC - 1);
   assign hf_tick   = hf_cnt_r == HW'(PWM_FREQ_SELECT_CYC - 1);
   assign lf_tick   = slow_edge && lf_cnt_r == SW'(SLOW_DIV - 1);
   assign ctrl_tick = o_external_clock_in_use ? slow_edge : osc_tick;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         slow_prev_r <= 1'b0;
      end else begin
         slow_prev_r <= i_slow_clock_input;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         osc_cnt_r <= '0;
      end else if (osc_tick) begin
         osc_cnt_r <= '0;
      end else begin
         osc_cnt_r <= osc_cnt_r + OW'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hf_cnt_r <= '0;
      end else if (hf_tick) begin
         hf_cnt_r <= '0;
      end else begin
         hf_cnt_r <= hf_cnt_r + HW'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lf_cnt_r <= '0;
      end else if (lf_tick) begin
         lf_cnt_r <= '0;
      end else if (slow_edge) begin
         lf_cnt_r <= lf_cnt_r + SW'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_ctrl_tick <= 1'b0;
         o_pwm_tick  <= 1'b0;
      end else begin
         o_ctrl_tick <= ctrl_tick;
         o_pwm_tick  <= o_cfg.pwm_freq_select ? hf_tick : lf_tick;
      end
   end

   // ==================================================
   // program counters, host writes made while the channel is held land on the next controller tick
   logic [2:0]      pc_pend_r;
   logic [2:0][3:0] pc_wval_r;

   for (genvar c = 0; c < 3; c++) begin : g_pc
      logic wr_hit;
      assign wr_hit = wr_en && i_reg_req.addr == `LRC_ADDR_PC_RED + 8'(c) && i_execution_mode_hold[c];

      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            pc_pend_r[c] <= 1'b0;
            pc_wval_r[c] <= `LRC_RST_PC;
         end else if (sreset) begin
            pc_pend_r[c] <= 1'b0;
            pc_wval_r[c] <= `LRC_RST_PC;
         end else if (wr_hit) begin
            pc_pend_r[c] <= 1'b1;
            pc_wval_r[c] <= i_reg_req.wdata[3:0];
         end else if (ctrl_tick) begin
            pc_pend_r[c] <= 1'b0;
         end
      end

      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            o_pc_value[c] <= `LRC_RST_PC;
         end else if (sreset) begin
            o_pc_value[c] <= `LRC_RST_PC;
         end else if (ctrl_tick && pc_pend_r[c]) begin
            o_pc_value[c] <= pc_wval_r[c];
         end else if (ctrl_tick && i_pc_step[c]) begin
            o_pc_value[c] <= o_pc_value[c] + 4'h1;
         end
      end
   end

   // ==================================================
   // channel interrupt flags, an arriving event beats the read clear
   logic [2:0] irq_flag_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_flag_r <= `LRC_RST_STATUS;
      end else if (sreset) begin
         irq_flag_r <= `LRC_RST_STATUS;
      end else begin
         irq_flag_r <= (irq_flag_r & ~{3{status_rd}}) | i_chan_irq;
      end
   end

   // ==================================================
   // output control register and pins
   logic [2:0] out_ctl_r;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         out_ctl_r <= `LRC_RST_OUTPUT_CTL;
      end else if (sreset) begin
         out_ctl_r <= `LRC_RST_OUTPUT_CTL;
      end else if (wr_en && i_reg_req.addr == `LRC_ADDR_OUTPUT_CTL) begin
         out_ctl_r <= i_reg_req.wdata[2:0];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_irq_pin_b          <= 1'b1;
         o_general_output_pin <= 1'b0;
         o_soft_reset         <= 1'b0;
      end else begin
         o_irq_pin_b          <= out_ctl_r[`LRC_OUT_IRQ_AS_OUT] ? out_ctl_r[`LRC_OUT_IRQ_LEVEL]
                                 : ~|irq_flag_r;
         o_general_output_pin <= out_ctl_r[`LRC_OUT_GEN_PIN];
         o_soft_reset         <= sreset;
      end
   end

   // ==================================================
   // program memory
   logic [7:0] mem_rdata;

   lrc_prog_mem #(
      .DEPTH (`LRC_MEM_DEPTH),
      .AW    (7),
      .DW    (8)
   ) u_mem (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_clear   (sreset),
      .i_wr      (wr_en && mem_hit),
      .i_addr    (mem_off[6:0]),
      .i_wdata   (i_reg_req.wdata),
      .o_rdata   (mem_rdata)
   );

   // ==================================================
   // two-stage answer
   logic       s1_vld_r;
   logic       s1_ack_r;
   logic       s1_mem_r;
   logic [7:0] s1_data_r;
   logic [7:0] reg_rdata;

   always_comb begin
      reg_rdata = 8'h00;
      if (i_reg_req.addr == `LRC_ADDR_CONFIG) begin
         reg_rdata = o_cfg;
      end else if (i_reg_req.addr == `LRC_ADDR_PC_RED) begin
         reg_rdata = {4'h0, o_pc_value[0]};
      end else if (i_reg_req.addr == `LRC_ADDR_PC_GREEN) begin
         reg_rdata = {4'h0, o_pc_value[1]};
      end else if (i_reg_req.addr == `LRC_ADDR_PC_BLUE) begin
         reg_rdata = {4'h0, o_pc_value[2]};
      end else if (i_reg_req.addr == `LRC_ADDR_STATUS) begin
         reg_rdata = {4'h0, o_external_clock_in_use, irq_flag_r[0], irq_flag_r[1], irq_flag_r[2]};
      end else if (i_reg_req.addr == `LRC_ADDR_OUTPUT_CTL) begin
         reg_rdata = {5'h00, out_ctl_r};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_vld_r  <= 1'b0;
         s1_ack_r  <= 1'b0;
         s1_mem_r  <= 1'b0;
         s1_data_r <= 8'h00;
         o_reg_rsp <= '0;
      end else begin
         s1_vld_r  <= i_reg_req.vld;
         s1_ack_r  <= !sreset;
         s1_mem_r  <= rd_en && mem_hit;
         s1_data_r <= rd_en ? reg_rdata : 8'h00;
         o_reg_rsp <= '{vld: s1_vld_r, ack: s1_ack_r, rdata: s1_mem_r ? mem_rdata : s1_data_r};
      end
   end

   // ==================================================
   // checks
   logic cfg_wr;
   assign cfg_wr = wr_en && i_reg_req.addr == `LRC_ADDR_CONFIG && !sreset;

   pwm_select_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      cfg_wr |=> o_cfg.pwm_freq_select == $past(i_reg_req.wdata[6]) && o_cfg.spare == 1'b0)
      else $error("pwm select bit not stored");
   save_enable_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      cfg_wr |=> o_cfg.power_save_enable == $past(i_reg_req.wdata[5]))
      else $error("power save bit not stored");
   pump_gain_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      cfg_wr |=> o_cfg.pump_gain_select == $past(i_reg_req.wdata[4:3]))
      else $error("pump gain field not stored");
   red_route_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      cfg_wr |=> o_cfg.red_supply_from_battery == $past(i_reg_req.wdata[2]))
      else $error("red supply bit not stored");
   clk_used_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      ##1 $past(i_rst_b) |-> o_external_clock_in_use == ($past(o_cfg.clk_src) == lrc_pkg::CLK_EXT
         || ($past(o_cfg.clk_src) == lrc_pkg::CLK_AUTO && $past(i_ext_clock_present))))
      else $error("clock in use flag wrong");
   pc_on_tick_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !$stable(o_pc_value) |-> $past(ctrl_tick) || $past(sreset))
      else $error("program counter moved off the controller tick");
   status_read_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      status_rd && !sreset |-> ##2 o_reg_rsp.vld && o_reg_rsp.rdata[3] == $past(o_external_clock_in_use, 2))
      else $error("status read lost clock state");
   irq_set_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      |i_chan_irq && !sreset |=> (irq_flag_r & $past(i_chan_irq)) == $past(i_chan_irq))
      else $error("channel interrupt flag not raised");
   irq_release_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      status_rd && i_chan_irq == 3'h0 ##1 i_chan_irq == 3'h0 && !out_ctl_r[`LRC_OUT_IRQ_AS_OUT]
      |=> irq_flag_r == 3'h0 && o_irq_pin_b)
      else $error("interrupt pin not released after status read");
   reset_nack_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      sreset |=> o_cfg == lrc_pkg::lrc_cfg_s'(`LRC_RST_CONFIG) ##1 o_reg_rsp.vld && !o_reg_rsp.ack)
      else $error("soft reset write answered or not applied");
   pin_reuse_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      ##1 $past(out_ctl_r[`LRC_OUT_IRQ_AS_OUT]) |-> o_irq_pin_b == $past(out_ctl_r[`LRC_OUT_IRQ_LEVEL]))
      else $error("reused interrupt pin level wrong");
   gen_pin_a : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      ##1 o_general_output_pin == $past(out_ctl_r[`LRC_OUT_GEN_PIN]))
      else $error("general output pin level wrong");

endmodule

// file: testbench/lrc_host_model.sv
// lrc_host_model: host on the register port, one byte transaction at a time
// assumes: called by the bench through hierarchical task calls, one clock
`timescale 1ns/1ps

module lrc_host_model #(
   parameter int PC_GAP = 16
) (
   // clock
   input  wire logic              i_ref_clk,
   // device side
   input  wire logic [2:0]        i_execution_mode_hold,
   input  wire lrc_pkg::lrc_rsp_s i_reg_rsp,
   output lrc_pkg::lrc_req_s      o_reg_req
);
   time last_pc_t = 0;

   initial begin
      o_reg_req = '0;
   end

   // ==================================================
   // one transaction; lat stays 0 when the host declines to send
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata, input bit rude,
                         output logic [7:0] rdata, output logic ack, output int lat);
      bit is_pc;
      is_pc = (addr >= 8'h09) && (addr <= 8'h0B);
      rdata = 8'h00;
      ack = 1'b0;
      lat = 0;
      if (is_pc && !rude && i_execution_mode_hold[addr[1:0] - 2'h1] !== 1'b1) begin
         return;
      end
      while (is_pc && wr && ($time - last_pc_t < PC_GAP * 10)) @(posedge i_ref_clk);
      @(posedge i_ref_clk);
      o_reg_req <= {1'b1, wr, addr, wdata};
      if (is_pc && wr) last_pc_t = $time;
      @(posedge i_ref_clk);
      o_reg_req.vld <= 1'b0;
      for (lat = 1; lat <= 8; lat++) begin
         @(posedge i_ref_clk);
         if (i_reg_rsp.vld === 1'b1) begin
            rdata = i_reg_rsp.rdata;
            ack = i_reg_rsp.ack;
            return;
         end
      end
   endtask
endmodule

// file: testbench/testbench.sv
// testbench: self-checking bench of the LED control register bank
// assumes: lrc_regs with shortened tick counts, host model on the register port
`timescale 1ns/1ps

module testbench;
   localparam int LIMIT = 5000;
   logic              i_ref_clk;
   logic              i_rst_b;
   lrc_pkg::lrc_req_s req;
   lrc_pkg::lrc_rsp_s rsp;
   lrc_pkg::lrc_cfg_s cfg;
   logic [2:0][3:0]   pc;
   logic [2:0]        hold, irq, step;
   logic              slow = 1'b0;
   logic              ext_ok, ext_used, ctrl_tick, pwm_tick, irq_b, output_pin_control, srst;
   logic [1:0]        sdiv = 2'h0;
   int                srst_n = 0;
   logic [7:0]        rd_v;
   logic              ack_v;
   int                lat_v;
   int                failures = 0;
   int                samples_checked = 0;
   int                cycles = 0;

   lrc_regs #(.INT_OSC_CYC(4), .PWM_FREQ_SELECT_CYC(8), .SLOW_DIV(4)) i_dut (
      .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_req(req), .o_reg_rsp(rsp), .i_execution_mode_hold(hold),
      .i_chan_irq(irq), .i_pc_step(step), .i_slow_clock_input(slow), .i_ext_clock_present(ext_ok),
      .o_cfg(cfg), .o_pc_value(pc), .o_external_clock_in_use(ext_used), .o_ctrl_tick(ctrl_tick),
      .o_pwm_tick(pwm_tick), .o_soft_reset(srst), .o_irq_pin_b(irq_b), .o_general_output_pin(output_pin_control));

   lrc_host_model #(.PC_GAP(16)) i_host (.i_ref_clk(i_ref_clk), .i_execution_mode_hold(hold), .i_reg_rsp(rsp), .o_reg_req(req));

   // ==================================================
   // clocks and timeout
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      sdiv <= (sdiv == 2'h2) ? 2'h0 : sdiv + 2'h1;
      if (sdiv == 2'h2) slow <= ~slow;
      if (srst === 1'b1) srst_n++;
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         results();
      end
   end

   // ==================================================
   // shared tasks
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
      i_host.access(1'b1, a, d, 1'b0, rd_v, ack_v, lat_v);
      check($sformatf("ack %h", a), ack_v, exp_ack);
      check("write latency", lat_v[15:0], 16'h0002);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_host.access(1'b0, a, 8'h00, 1'b0, rd_v, ack_v, lat_v);
      check($sformatf("read %h", a), rd_v, exp);
      check("read latency", lat_v[15:0], 16'h0002);
   endtask

   task automatic ticks(input int n, output int np, output int nc);
      np = 0;
      nc = 0;
      repeat (n) begin
         @(posedge i_ref_clk);
         np += (pwm_tick === 1'b1);
         nc += (ctrl_tick === 1'b1);
      end
   endtask

   // ==================================================
   // scenarios
   task automatic t_reset();
      check("irq pin idle", irq_b, 1'b1);
      check("general pin idle", output_pin_control, 1'b0);
      for (int a = 8; a <= 14; a++) rd(a[7:0], (a == 12) ? 8'h08 : 8'h00);
      rd(8'h70, 8'h00);
   endtask

   task automatic t_config();
      logic [7:0] v;
      logic       e;
      int         np, nc;
      for (int i = 0; i < 16; i++) begin
         v = {1'b0, i[0], ~i[0], i[3:2], i[1], i[1:0]};
         e = (v[1:0] == 2'b00) || (v[1:0] == 2'b10 && i[2]);
         ext_ok <= i[2];
         wr(8'h08, v, 1'b1);
         check("config out", cfg, v);
         rd(8'h08, v);
         check("ext clock used", ext_used, e);
         rd(8'h0C, {4'h0, e, 3'h0});
      end
      wr(8'h08, 8'h41, 1'b1);
      repeat (24) @(posedge i_ref_clk);
      ticks(80, np, nc);
      check("fast pwm ticks", np[15:0], 16'h000A);
      check("internal ticks", nc[15:0], 16'h0014);
      wr(8'h08, 8'h00, 1'b1);
      repeat (48) @(posedge i_ref_clk);
      ticks(240, np, nc);
      check("slow pwm ticks", np[15:0], 16'h000A);
      check("external ticks", nc[15:0], 16'h0028);
   endtask

   task automatic t_pc();
      for (int c = 0; c < 3; c++) begin
         wr(8'h09 + c[7:0], 8'hF0 | (8'h05 * (c[7:0] + 8'h01)), 1'b1);
         repeat (10) @(posedge i_ref_clk);
         check("pc out", pc[c], 16'h0005 * (c[15:0] + 16'h0001));
         rd(8'h09 + c[7:0], 8'h05 * (c[7:0] + 8'h01));
      end
      hold <= 3'b101;
      i_host.access(1'b1, 8'h0A, 8'h03, 1'b1, rd_v, ack_v, lat_v);
      check("ack without hold", ack_v, 1'b1);
      repeat (20) @(posedge i_ref_clk);
      check("pc without hold", pc[1], 16'h000A);
      hold <= 3'b111;
      step <= 3'b100;
      repeat (24) @(posedge i_ref_clk);
      step <= 3'b000;
      @(posedge i_ref_clk);
      check("pc stepped", pc[2], 16'h0003);
   endtask

   task automatic t_status();
      irq <= 3'b011;
      @(posedge i_ref_clk);
      irq <= 3'b000;
      repeat (3) @(posedge i_ref_clk);
      check("irq pin asserted", irq_b, 1'b0);
      rd(8'h0C, 8'h0E);
      check("irq pin released", irq_b, 1'b1);
      rd(8'h0C, 8'h08);
   endtask

   task automatic t_outctl();
      logic [7:0] ov [3] = '{8'h02, 8'h04, 8'h05};
      for (int i = 0; i < 3; i++) begin
         wr(8'h0E, ov[i], 1'b1);
         @(posedge i_ref_clk);
         check("general pin", output_pin_control, ov[i][1]);
         check("irq pin", irq_b, ov[i][2] ? ov[i][0] : 1'b1);
      end
      rd(8'h0E, 8'h05);
   endtask

   task automatic t_mem_reset();
      logic [7:0] ra [7] = '{8'h08, 8'h09, 8'h0B, 8'h0E, 8'h10, 8'h11, 8'h6F};
      wr(8'h10, 8'h03, 1'b1);
      wr(8'h11, 8'h7F, 1'b1);
      wr(8'h6F, 8'hA5, 1'b1);
      rd(8'h10, 8'h03);
      rd(8'h11, 8'h7F);
      rd(8'h6F, 8'hA5);
      wr(8'h08, 8'h39, 1'b1);
      wr(8'h0D, 8'h12, 1'b1);
      rd(8'h6F, 8'hA5);
      check("no soft reset pulse", srst_n, 16'h0000);
      wr(8'h0D, 8'hFF, 1'b0);
      check("soft reset pulses", srst_n, 16'h0001);
      foreach (ra[i]) rd(ra[i], 8'h00);
      check("irq pin after reset", irq_b, 1'b1);
      check("general pin after reset", output_pin_control, 1'b0);
   endtask

   task automatic results();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==================================================
   // main sequence
   initial begin
      i_rst_b = 1'b0;
      hold = 3'b111;
      irq = 3'b000;
      step = 3'b000;
      ext_ok = 1'b0;
      repeat (4) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      @(posedge i_ref_clk);
      t_reset();
      t_config();
      t_pc();
      t_status();
      t_outctl();
      t_mem_reset();
      results();
   end
endmodule
